// ===== boot_strap_pkg.sv
// shared constants and types for the strap latch boot configuration block
package boot_strap_pkg;

   // ***************************************************************
   // strap bit positions and pull defaults
   // ***************************************************************
   localparam int STRAP_W = 5;
   localparam int STRAP_A_BIT = 0;
   localparam int STRAP_B_BIT = 1;
   localparam int STRAP_C_BIT = 2;
   localparam int STRAP_D_BIT = 3;
   localparam int STRAP_E_BIT = 4;
   // only strap b has a weak pull-up; the rest float
   localparam logic [4:0] PULL_UP_RST = 5'h02;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int HOLD_MS = 3;
   localparam int CLK_KHZ = 250000;
   localparam int HOLD_CYCLES = HOLD_MS * CLK_KHZ;
   localparam int SYNC_STAGES = 2;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic e;
      logic d;
      logic c;
      logic b;
      logic a;
   } strap_t;

   typedef struct packed {
      logic usb_serial_disable;
      logic debug_select_enable;
      logic usb_debug_disable;
      logic pad_debug_disable;
      logic usb_print_disable;
      logic [1:0] serial_print;
   } fuse_t;

   localparam int FUSE_W = 7;
   localparam logic [6:0] FUSE_RST = 7'h00;
   localparam logic [4:0] STRAP_RST = 5'h00;

   typedef enum logic [1:0] {
      BOOT_NONE = 2'h0,
      BOOT_SPI = 2'h1,
      BOOT_JOINT = 2'h2
   } boot_mode_t;

   typedef enum logic [1:0] {
      DBG_USB = 2'h0,
      DBG_PINS = 2'h1,
      DBG_OFF = 2'h2
   } debug_src_t;

   typedef struct packed {
      boot_mode_t boot_mode;
      logic sample_rise;
      logic drive_rise;
      logic serial_print_en;
      logic usb_print_en;
      debug_src_t debug_src;
   } boot_cfg_t;

   localparam boot_cfg_t CFG_RST = '{boot_mode: BOOT_NONE, sample_rise: 1'b0, drive_rise: 1'b0,
                                     serial_print_en: 1'b0, usb_print_en: 1'b0, debug_src: DBG_OFF};

   typedef enum logic [2:0] {
      ST_OFF = 3'h1,
      ST_SAMPLE = 3'h2,
      ST_RUN = 3'h4
   } boot_state_t;

endpackage

// ===== level_sync.sv
// two-stage synchroniser for a bus of independent pin levels
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 6
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   if (WIDTH < 1) begin : g_bad_width
      $error("level_sync width must be positive");
   end

   // ***************************************************************
   // per-bit stages
   // ***************************************************************
   // first stage feeds only the second; bits are not coherent as a word
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk_in) begin
         if (srst_in) begin
            meta_r[i] <= 1'b0;
            sync_r[i] <= 1'b0;
         end else begin
            meta_r[i] <= async_in[i];
            sync_r[i] <= meta_r[i];
         end
      end
   end

   assign sync_out = sync_r;

endmodule // level_sync
`default_nettype wire

// ===== boot_cfg_decode.sv
// decodes latched straps and fuse snapshot into boot selections
`timescale 1ns/100ps
`default_nettype none
module boot_cfg_decode (
   // latched inputs
   input wire boot_strap_pkg::strap_t strap_in,
   input wire boot_strap_pkg::fuse_t fuse_in,
   // selections
   output boot_strap_pkg::boot_cfg_t cfg_out
);

   always_comb begin
      cfg_out = boot_strap_pkg::CFG_RST;
      if (strap_in.b) begin
         cfg_out.boot_mode = boot_strap_pkg::BOOT_SPI;
      end else if (strap_in.a) begin
         cfg_out.boot_mode = boot_strap_pkg::BOOT_JOINT;
      end else begin
         cfg_out.boot_mode = boot_strap_pkg::BOOT_NONE;
      end
      cfg_out.sample_rise = strap_in.c;
      cfg_out.drive_rise = strap_in.d;
      case (fuse_in.serial_print)
         2'h0: cfg_out.serial_print_en = 1'b1;
         2'h1: cfg_out.serial_print_en = ~strap_in.a;
         2'h2: cfg_out.serial_print_en = strap_in.a;
         default: cfg_out.serial_print_en = 1'b0;
      endcase
      cfg_out.usb_print_en = ~fuse_in.usb_serial_disable & ~fuse_in.usb_print_disable;
      case ({fuse_in.pad_debug_disable, fuse_in.usb_debug_disable})
         2'h0: begin
            if (fuse_in.debug_select_enable && !strap_in.e) begin
               cfg_out.debug_src = boot_strap_pkg::DBG_PINS;
            end else begin
               cfg_out.debug_src = boot_strap_pkg::DBG_USB;
            end
         end
         2'h2: cfg_out.debug_src = boot_strap_pkg::DBG_USB;
         2'h1: cfg_out.debug_src = boot_strap_pkg::DBG_PINS;
         default: cfg_out.debug_src = boot_strap_pkg::DBG_OFF;
      endcase
   end

endmodule // boot_cfg_decode
`default_nettype wire

// ===== strap_latch_boot_config.sv
// strap sampling, latch, fuse store and boot configuration outputs
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - run while power-up pin high; hold disabled while it is low
// - boot parameters come only from strap levels and fuses, no firmware
// - straps a,b boot; c,d edges; a plus fuses print; e plus fuses debug
// - each strap has a latch sampled at reset, kept until power-down
// - captured latch changes only when srst_in clears it or at the next power-down
// - after capture pins become general purpose; latched values stay available
// - straps held 3 ms after power-up; sample inside, then release pins
// - unconnected strap b pulls up to 1; others float
// - unprogrammed fuse bits read 0
// - fuse bits only ever set by programming; srst_in clears them back to 0
// - b=1 selects flash boot; a=1,b=0 selects joint download
// - c selects sampling edge, d driving edge; 1 rising, 0 falling
// - debug source from disable fuses, select-enable fuse and strap e
module strap_latch_boot_config #(
   parameter int unsigned HOLD_CYCLES = boot_strap_pkg::HOLD_CYCLES
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // pins
   input wire logic power_up_pin_in,
   input wire logic strap_pin_a_in,
   input wire logic strap_pin_b_in,
   input wire logic strap_pin_c_in,
   input wire logic strap_pin_d_in,
   input wire logic strap_pin_e_in,
   // fuse programming from the fuse controller
   input wire boot_strap_pkg::fuse_t fuse_prog_in,
   // status
   output logic chip_enable_out,
   output logic pins_released_out,
   output logic config_valid_out,
   output logic [4:0] pull_up_en_out,
   // configuration
   output boot_strap_pkg::strap_t strap_latched_out,
   output boot_strap_pkg::fuse_t fuse_out,
   output boot_strap_pkg::boot_cfg_t boot_cfg_out
);

   localparam int CW = $clog2(HOLD_CYCLES + 1);
   // two sync stages lag the pin, so sampling sits three cycles early
   // to read the straps before the hold window closes
   localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 3);

   // a shorter window leaves no cycle for the sample point
   if (HOLD_CYCLES < 3) begin : g_bad_hold
      $error("hold window must be at least three cycles");
   end

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic [5:0] pins_async;
   logic [5:0] pins_sync;
   logic pu_s;
   boot_strap_pkg::strap_t strap_s;

   assign pins_async = {strap_pin_e_in, strap_pin_d_in, strap_pin_c_in,
                        strap_pin_b_in, strap_pin_a_in, power_up_pin_in};

   level_sync #(
      .WIDTH(6)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .async_in(pins_async),
      .sync_out(pins_sync)
   );

   assign pu_s = pins_sync[0];
   assign strap_s = boot_strap_pkg::strap_t'(pins_sync[5:1]);

   // ***************************************************************
   // power state machine
   // ***************************************************************
   boot_strap_pkg::boot_state_t state_r;
   boot_strap_pkg::boot_state_t state_nxt;
   logic [CW-1:0] cnt_r;
   logic capture;

   // sampling point lies inside the hold window, ahead of the sync lag
   assign capture = (state_r == boot_strap_pkg::ST_SAMPLE) && pu_s && (cnt_r == CNT_LAST);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         boot_strap_pkg::ST_OFF: begin
            if (pu_s) begin
               state_nxt = boot_strap_pkg::ST_SAMPLE;
            end
         end
         boot_strap_pkg::ST_SAMPLE: begin
            if (!pu_s) begin
               state_nxt = boot_strap_pkg::ST_OFF;
            end else if (capture) begin
               state_nxt = boot_strap_pkg::ST_RUN;
            end
         end
         boot_strap_pkg::ST_RUN: begin
            if (!pu_s) begin
               state_nxt = boot_strap_pkg::ST_OFF;
            end
         end
         default: state_nxt = boot_strap_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state_r <= boot_strap_pkg::ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         cnt_r <= '0;
      end else if (state_r == boot_strap_pkg::ST_SAMPLE && pu_s && !capture) begin
         cnt_r <= cnt_r + CW'(1);
      end else begin
         cnt_r <= '0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         chip_enable_out <= 1'b0;
      end else begin
         chip_enable_out <= pu_s && (state_r != boot_strap_pkg::ST_OFF);
      end
   end

   // ***************************************************************
   // fuse store
   // ***************************************************************
   boot_strap_pkg::fuse_t fuse_r;
   boot_strap_pkg::fuse_t fuse_lat_r;

   // blank store reads zero; programming only ever sets bits
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         fuse_r <= boot_strap_pkg::fuse_t'(boot_strap_pkg::FUSE_RST);
      end else begin
         fuse_r <= fuse_r | fuse_prog_in;
      end
   end

   assign fuse_out = fuse_r;

   // ***************************************************************
   // strap latches and fuse snapshot
   // ***************************************************************
   // capture once per power-up; cleared at power-down, no other write path
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         strap_latched_out <= boot_strap_pkg::strap_t'(boot_strap_pkg::STRAP_RST);
      end else if (capture) begin
         strap_latched_out <= strap_s;
      end else if (!pu_s) begin
         strap_latched_out <= boot_strap_pkg::strap_t'(boot_strap_pkg::STRAP_RST);
      end
   end

   // fuses snapshot with the straps so later programming stays out
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         fuse_lat_r <= boot_strap_pkg::fuse_t'(boot_strap_pkg::FUSE_RST);
      end else if (capture) begin
         fuse_lat_r <= fuse_r;
      end
   end

   // weak pull-up on strap b only, held from reset
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pull_up_en_out <= boot_strap_pkg::PULL_UP_RST;
      end else begin
         pull_up_en_out <= boot_strap_pkg::PULL_UP_RST;
      end
   end

   // ***************************************************************
   // decoded configuration
   // ***************************************************************
   boot_strap_pkg::boot_cfg_t cfg_dec;

   boot_cfg_decode u_decode (
      .strap_in(strap_latched_out),
      .fuse_in(fuse_lat_r),
      .cfg_out(cfg_dec)
   );

   // outputs valid one cycle into run, frozen until power-down
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         boot_cfg_out <= boot_strap_pkg::CFG_RST;
         config_valid_out <= 1'b0;
      end else if (state_r == boot_strap_pkg::ST_RUN && pu_s && !config_valid_out) begin
         boot_cfg_out <= cfg_dec;
         config_valid_out <= 1'b1;
      end else if (!pu_s) begin
         boot_cfg_out <= boot_strap_pkg::CFG_RST;
         config_valid_out <= 1'b0;
      end
   end

   // pins handed to general use with the valid configuration
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pins_released_out <= 1'b0;
      end else begin
         pins_released_out <= pu_s && (state_r == boot_strap_pkg::ST_RUN);
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   // pu_s high time seen by the checks, saturating at the window length
   logic [CW-1:0] pu_hi_cnt_r;

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pu_hi_cnt_r <= '0;
      end else if (!pu_s) begin
         pu_hi_cnt_r <= '0;
      end else if (pu_hi_cnt_r != CW'(HOLD_CYCLES)) begin
         pu_hi_cnt_r <= pu_hi_cnt_r + CW'(1);
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);

   power_off_a: assert property (!pu_s |=> ##1 (!chip_enable_out && !config_valid_out))
      else $error("outputs active while power pin low");

   latch_value_a: assert property (capture |=> strap_latched_out == $past(strap_s))
      else $error("strap latch did not take sampled levels");

   // latch only moves on capture or power-down
   latch_frozen_a: assert property (pu_s && !capture |=> $stable(strap_latched_out))
      else $error("strap latch changed without capture");

   release_valid_a: assert property (pins_released_out && $past(pu_s) |-> config_valid_out)
      else $error("pins released before configuration valid");

   // release two edges after the capture cycle
   release_timing_a: assert property ($rose(pins_released_out) |-> $past(capture, 2))
      else $error("pins released outside the hold window end");

   fuse_sticky_a: assert property (1'b1 |=> (fuse_r & $past(fuse_r)) == $past(fuse_r))
      else $error("programmed fuse bit returned to zero");

   boot_flash_a: assert property (config_valid_out && strap_latched_out.b
                                  |-> boot_cfg_out.boot_mode == boot_strap_pkg::BOOT_SPI)
      else $error("strap b high but not flash boot");

   // edges follow straps c and d
   edge_sel_a: assert property (config_valid_out |-> boot_cfg_out.sample_rise == strap_latched_out.c
                                && boot_cfg_out.drive_rise == strap_latched_out.d)
      else $error("card edge select mismatch");

   debug_off_a: assert property (config_valid_out && fuse_lat_r.pad_debug_disable
                                 && fuse_lat_r.usb_debug_disable
                                 |-> boot_cfg_out.debug_src == boot_strap_pkg::DBG_OFF)
      else $error("debug not disabled with both disable fuses");

   cfg_stable_a: assert property (config_valid_out && pu_s |=> !config_valid_out || $stable(boot_cfg_out))
      else $error("configuration changed while valid");

   chip_on_a: assert property ($rose(pu_s) ##1 pu_s |=> chip_enable_out)
      else $error("chip not enabled after power pin rose");

   sample_window_a: assert property (capture |-> pu_hi_cnt_r <= CW'(HOLD_CYCLES - 2))
      else $error("straps sampled after the hold window");

   release_hold_a: assert property (pins_released_out |-> pu_hi_cnt_r >= CW'(HOLD_CYCLES))
      else $error("pins released inside the hold window");

   fuse_frozen_a: assert property (config_valid_out && pu_s |=> $stable(fuse_lat_r))
      else $error("fuse snapshot changed after capture");

   release_off_a: assert property (!pu_s |=> !pins_released_out)
      else $error("pins still released while power pin low");

   spi_boot_c: cover property (config_valid_out && boot_cfg_out.boot_mode == boot_strap_pkg::BOOT_SPI);
   joint_boot_c: cover property (config_valid_out && boot_cfg_out.boot_mode == boot_strap_pkg::BOOT_JOINT);
   pins_debug_c: cover property (config_valid_out && boot_cfg_out.debug_src == boot_strap_pkg::DBG_PINS);
   power_cycle_c: cover property (config_valid_out ##1 !config_valid_out);
   released_c: cover property ($rose(pins_released_out));

endmodule // strap_latch_boot_config
`default_nettype wire

// ===== strap_board_model.sv
// board side of the strap pins: drivers, weak pulls and floating lines
`timescale 1ns/100ps
`default_nettype none
module strap_board_model (
   // clock
   input wire logic core_clk_in,
   // board drivers, bit i = strap a..e
   input wire logic [4:0] drive_en_in,
   input wire logic [4:0] drive_val_in,
   // weak pull-ups enabled inside the device
   input wire logic [4:0] pull_up_en_in,
   // resolved pin levels
   output logic [4:0] pin_level_out
);
   // ***************************************************************
   // pin resolution
   // ***************************************************************
   logic toggle_r;

   initial toggle_r = 1'b0;

   // floating lines wander so a stale level never passes as a default
   always @(posedge core_clk_in) begin
      toggle_r <= ~toggle_r;
   end

   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (drive_en_in[i]) begin
            pin_level_out[i] = drive_val_in[i];
         end else if (pull_up_en_in[i]) begin
            pin_level_out[i] = 1'b1;
         end else begin
            pin_level_out[i] = toggle_r ^ i[0];
         end
      end
   end
endmodule // strap_board_model
`default_nettype wire

// ===== test_strap_latch_boot_config.sv
// self-checking bench for the strap latch boot configuration block
`timescale 1ns/100ps
`default_nettype none
module test_strap_latch_boot_config;
   // ***************************************************************
   // signals
   // ***************************************************************
   localparam int HOLD = 16;
   logic core_clk_in, srst_in, power_up_pin_in;
   logic [4:0] drive_en, drive_val, pins, pull_up_en;
   boot_strap_pkg::fuse_t fuse_prog, fuse_seen;
   logic chip_en, released, cfg_valid;
   boot_strap_pkg::strap_t latched;
   boot_strap_pkg::boot_cfg_t cfg;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   strap_latch_boot_config #(.HOLD_CYCLES(HOLD)) u_dut (
      .core_clk_in(core_clk_in), .srst_in(srst_in), .power_up_pin_in(power_up_pin_in),
      .strap_pin_a_in(pins[0]), .strap_pin_b_in(pins[1]), .strap_pin_c_in(pins[2]),
      .strap_pin_d_in(pins[3]), .strap_pin_e_in(pins[4]), .fuse_prog_in(fuse_prog),
      .chip_enable_out(chip_en), .pins_released_out(released), .config_valid_out(cfg_valid),
      .pull_up_en_out(pull_up_en), .strap_latched_out(latched), .fuse_out(fuse_seen),
      .boot_cfg_out(cfg));

   strap_board_model u_board (
      .core_clk_in(core_clk_in), .drive_en_in(drive_en), .drive_val_in(drive_val),
      .pull_up_en_in(pull_up_en), .pin_level_out(pins));

   // ***************************************************************
   // clock, timeout, helpers
   // ***************************************************************
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end

   // ceiling is far above eight power cycles of some forty clocks
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   function automatic boot_strap_pkg::boot_cfg_t exp_cfg(boot_strap_pkg::strap_t s, boot_strap_pkg::fuse_t f);
      boot_strap_pkg::boot_cfg_t c;
      c.boot_mode = s.b ? boot_strap_pkg::BOOT_SPI : (s.a ? boot_strap_pkg::BOOT_JOINT : boot_strap_pkg::BOOT_NONE);
      c.sample_rise = s.c;
      c.drive_rise = s.d;
      c.serial_print_en = (f.serial_print == 2'h0) || (f.serial_print == 2'h1 && !s.a) ||
                          (f.serial_print == 2'h2 && s.a);
      c.usb_print_en = !f.usb_serial_disable && !f.usb_print_disable;
      if (f.pad_debug_disable && f.usb_debug_disable) c.debug_src = boot_strap_pkg::DBG_OFF;
      else if (f.usb_debug_disable) c.debug_src = boot_strap_pkg::DBG_PINS;
      else if (f.pad_debug_disable || !f.debug_select_enable || s.e) c.debug_src = boot_strap_pkg::DBG_USB;
      else c.debug_src = boot_strap_pkg::DBG_PINS;
      return c;
   endfunction

   // ***************************************************************
   // one power cycle with given straps and fuses
   // ***************************************************************
   task automatic run_case(input logic [4:0] s, input logic [6:0] f, input logic [4:0] en);
      boot_strap_pkg::strap_t exp_s;
      int cnt;
      exp_s = en[1] ? s : (s | 5'h02);
      srst_in = 1'b1;
      power_up_pin_in = 1'b0;
      tick(3);
      srst_in = 1'b0;
      tick(1);
      check("chip_enable_off", chip_en, 1'b0);
      check("strap_reset", latched, 5'h00);
      check("cfg_reset", cfg, boot_strap_pkg::CFG_RST);
      check("pull_up_en", pull_up_en, 5'h02);
      check("fuse_blank", fuse_seen, 7'h00);
      fuse_prog = f;
      tick(1);
      fuse_prog = 7'h00;
      tick(1);
      check("fuse_programmed", fuse_seen, f);
      drive_en = en;
      drive_val = s;
      power_up_pin_in = 1'b1;
      tick(5);
      check("chip_enable_on", chip_en, 1'b1);
      check("pins_held", released, 1'b0);
      cnt = 5;
      while (!cfg_valid && cnt < 200) begin
         tick(1);
         cnt++;
         // hold time met: the board may reuse the pins from here on
         if (cnt == HOLD) begin
            drive_val = ~s;
         end
      end
      check("release_delay", (cnt >= HOLD) && (cnt <= HOLD + 8), 1'b1);
      check("pins_released", released, 1'b1);
      check("latched_straps", latched, exp_s);
      check("boot_cfg", cfg, exp_cfg(exp_s, f));
      // pins now serve as plain io; fuse controller burns everything
      drive_en = 5'h1F;
      drive_val = ~s;
      fuse_prog = 7'h7F;
      tick(1);
      fuse_prog = 7'h00;
      tick(6);
      check("fuse_sticky", fuse_seen, 7'h7F);
      check("latched_kept", latched, exp_s);
      check("cfg_kept", cfg, exp_cfg(exp_s, f));
      check("valid_kept", cfg_valid, 1'b1);
      power_up_pin_in = 1'b0;
      tick(6);
      check("powered_down", chip_en, 1'b0);
      check("valid_cleared", cfg_valid, 1'b0);
      check("released_cleared", released, 1'b0);
      check("latched_cleared", latched, 5'h00);
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      srst_in = 1'b1;
      power_up_pin_in = 1'b0;
      drive_en = 5'h1F;
      drive_val = 5'h00;
      fuse_prog = 7'h00;
      tick(2);
      run_case(5'h00, 7'h00, 5'h1F);
      run_case(5'h01, 7'h01, 5'h1F);
      run_case(5'h1E, 7'h22, 5'h1F);
      run_case(5'h0F, 7'h23, 5'h1F);
      run_case(5'h05, 7'h0A, 5'h1F);
      run_case(5'h08, 7'h14, 5'h1F);
      run_case(5'h00, 7'h59, 5'h1F);
      // strap b left open must read as one
      run_case(5'h00, 7'h00, 5'h1D);
      test_done();
   end
endmodule // test_strap_latch_boot_config
`default_nettype wire
